// [hw/tcp_pair.sv]
// Chosen here: the address-and-strobe port and the placing of the registers.
module tcp_pair
  import tcp_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // register port
  input tcp_bus_s bus_i,
  output logic [7:0] rdata_o,
  // low-speed clock pin
  input wire logic low_speed_clock_i,
  // pwm pins
  output logic pwm_out_pin_lower_o,
  output logic pwm_out_pin_upper_o,
  // interrupt requests, one-cycle pulses
  output logic counter_period_irq_o,
  output logic upper_counter_irq_o
);

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic ls_meta;
    logic ls_sync;
    logic ls_prev;
    logic [2:0] ls_div;
    tcp_ctrl_s lower_counter_control;
    tcp_ctrl_s upper_counter_control;
    logic [7:0] interval_compare_low;
    logic [7:0] interval_compare_high;
    logic divider_tap_select;
    logic slow_mode;
    logic [7:0] rdata;
    logic counter_period_irq;
    logic upper_counter_irq;
  } tcp_top_s;

  localparam tcp_top_s TOP_RESET = '{
    div: '0, ls_meta: 1'b0, ls_sync: 1'b0, ls_prev: 1'b0, ls_div: 3'h0,
    lower_counter_control: CTRL_RESET, upper_counter_control: CTRL_RESET,
    interval_compare_low: CMP_RESET, interval_compare_high: CMP_RESET,
    divider_tap_select: 1'b0, slow_mode: 1'b0, rdata: 8'h00,
    counter_period_irq: 1'b0, upper_counter_irq: 1'b0};

  // ==========================================
  // reset release
  logic [1:0] rst_pipe_reg;
  logic rst_n;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe_reg[1];

  tcp_top_s state_reg;
  tcp_top_s state_next;
  tcp_chan_cmd_s lower_cmd;
  tcp_chan_cmd_s upper_cmd;
  tcp_chan_stat_s lower_stat;
  tcp_chan_stat_s upper_stat;

  // ==========================================
  // prescaler taps
  logic ls_tick;
  logic ls8_tick;

  always_comb begin
    ls_tick = state_reg.ls_sync && !state_reg.ls_prev;
    ls8_tick = ls_tick && (state_reg.ls_div == LS_DIV_LAST);
  end

  function automatic logic tap(input logic [2:0] sel, input logic [DIV_W-1:0] div,
                               input logic dv7, input logic slow, input logic ls,
                               input logic ls8);
    logic t;
    t = 1'b0;
    // system-derived taps are dead in slow mode
    unique case (sel)
      SEL_SLOWEST: t = (dv7 || slow) ? ls8 : ((div & DIV_MASK_2048) == DIV_MASK_2048);
      SEL_HS_128: t = !slow && ((div & DIV_MASK_128) == DIV_MASK_128);
      SEL_HS_32: t = !slow && ((div & DIV_MASK_32) == DIV_MASK_32);
      SEL_HS_8: t = !slow && ((div & DIV_MASK_8) == DIV_MASK_8);
      SEL_LS: t = ls;
      SEL_HS_2: t = !slow && ((div & DIV_MASK_2) == DIV_MASK_2);
      SEL_HS: t = !slow;
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  logic tick_lower;
  logic tick_upper;

  always_comb begin
    tick_lower = tap(state_reg.lower_counter_control.clk_sel, state_reg.div,
                     state_reg.divider_tap_select, state_reg.slow_mode,
                     ls_tick, ls8_tick);
    tick_upper = tap(state_reg.upper_counter_control.clk_sel, state_reg.div,
                     state_reg.divider_tap_select, state_reg.slow_mode,
                     ls_tick, ls8_tick);
  end

  // ==========================================
  // cascade
  logic cascade;
  logic casc_tick;
  logic [15:0] count16_next;
  logic casc_match;
  logic casc_run;

  always_comb begin
    cascade = (state_reg.lower_counter_control.mode == MODE_TIMER16);
    casc_run = state_reg.upper_counter_control.run;
    casc_tick = cascade && state_reg.upper_counter_control.run && tick_lower;
    count16_next = {upper_stat.count, lower_stat.count} + 16'h0001;
    casc_match = casc_tick && (count16_next ==
      {state_reg.interval_compare_high, state_reg.interval_compare_low});
  end

  // ==========================================
  // bus decode
  logic wr_lower_ctrl;
  logic wr_upper_ctrl;

  always_comb begin
    wr_lower_ctrl = bus_i.wr && (bus_i.addr == ADDR_LOWER_CTRL);
    wr_upper_ctrl = bus_i.wr && (bus_i.addr == ADDR_UPPER_CTRL);
  end

  // ==========================================
  // channel commands
  always_comb begin
    lower_cmd.pwm_en = (state_reg.lower_counter_control.mode == MODE_PWM8);
    lower_cmd.run = state_reg.lower_counter_control.run;
    lower_cmd.tick = tick_lower;
    lower_cmd.casc_inc = casc_tick;
    // a stopped counter restarts from zero, so a restart keeps the preset polarity
    lower_cmd.casc_clr = casc_match ||
      (cascade ? !casc_run : !(lower_cmd.pwm_en && lower_cmd.run));
    lower_cmd.duty_wr = bus_i.wr && (bus_i.addr == ADDR_DUTY_LOWER);
    // preset taken only from a write landing on a stopped channel
    lower_cmd.ff_wr = wr_lower_ctrl && !state_reg.lower_counter_control.run;
    lower_cmd.ff_val = bus_i.wdata[CTRL_FFINIT_BIT];
    lower_cmd.wdata = bus_i.wdata;

    upper_cmd.pwm_en = !cascade && (state_reg.upper_counter_control.mode == MODE_PWM8);
    upper_cmd.run = state_reg.upper_counter_control.run;
    upper_cmd.tick = tick_upper;
    upper_cmd.casc_inc = casc_tick && (lower_stat.count == COUNT_MAX);
    upper_cmd.casc_clr = casc_match ||
      (cascade ? !casc_run : !(upper_cmd.pwm_en && upper_cmd.run));
    upper_cmd.duty_wr = bus_i.wr && (bus_i.addr == ADDR_DUTY_UPPER);
    upper_cmd.ff_wr = wr_upper_ctrl && !state_reg.upper_counter_control.run;
    upper_cmd.ff_val = bus_i.wdata[CTRL_FFINIT_BIT];
    upper_cmd.wdata = bus_i.wdata;
  end

  tcp_chan u_lower (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .cmd_i(lower_cmd),
    .stat_o(lower_stat)
  );

  tcp_chan u_upper (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .cmd_i(upper_cmd),
    .stat_o(upper_stat)
  );

  // ==========================================
  // next state
  always_comb begin
    state_next = state_reg;
    state_next.div = state_reg.div + 11'h001;
    state_next.ls_meta = low_speed_clock_i;
    state_next.ls_sync = state_reg.ls_meta;
    state_next.ls_prev = state_reg.ls_sync;
    if (ls_tick) begin
      state_next.ls_div = state_reg.ls_div + 3'h1;
    end
    if (bus_i.wr) begin
      unique case (bus_i.addr)
        ADDR_LOWER_CTRL: state_next.lower_counter_control = bus_i.wdata;
        ADDR_UPPER_CTRL: state_next.upper_counter_control = bus_i.wdata;
        ADDR_CMP_LOW: state_next.interval_compare_low = bus_i.wdata;
        ADDR_CMP_HIGH: state_next.interval_compare_high = bus_i.wdata;
        ADDR_CONFIG: begin
          state_next.divider_tap_select = bus_i.wdata[CFG_DIVTAP_BIT];
          state_next.slow_mode = bus_i.wdata[CFG_SLOW_BIT];
        end
        default: state_next.rdata = state_reg.rdata;
      endcase
    end
    state_next.rdata = 8'h00;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        ADDR_LOWER_CTRL: state_next.rdata = state_reg.lower_counter_control;
        ADDR_UPPER_CTRL: state_next.rdata = state_reg.upper_counter_control;
        ADDR_CMP_LOW: state_next.rdata = state_reg.interval_compare_low;
        ADDR_CMP_HIGH: state_next.rdata = state_reg.interval_compare_high;
        ADDR_DUTY_LOWER: state_next.rdata = lower_stat.duty;
        ADDR_DUTY_UPPER: state_next.rdata = upper_stat.duty;
        ADDR_COUNT_LOW: state_next.rdata = lower_stat.count;
        ADDR_COUNT_HIGH: state_next.rdata = upper_stat.count;
        ADDR_CONFIG: state_next.rdata = {6'h00, state_reg.slow_mode,
                                         state_reg.divider_tap_select};
        ADDR_STATUS: state_next.rdata = {6'h00, upper_stat.output_flipflop,
                                         lower_stat.output_flipflop};
        default: state_next.rdata = 8'h00;
      endcase
    end
    state_next.counter_period_irq = lower_stat.period;
    state_next.upper_counter_irq = upper_stat.period || casc_match;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= TOP_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================
  // outputs
  always_comb begin
    rdata_o = state_reg.rdata;
    pwm_out_pin_lower_o = lower_stat.pwm_out_pin;
    pwm_out_pin_upper_o = upper_stat.pwm_out_pin;
    counter_period_irq_o = state_reg.counter_period_irq;
    upper_counter_irq_o = state_reg.upper_counter_irq;
  end

endmodule // tcp_pair

// [hw/tcp_pkg.sv]
// Function
// - pwm8: counter counts source ticks; match with duty toggles flip-flop, no clear
// - pwm8: overflow toggles flip-flop again, clears counter, raises period irq
// - initial-level bit presets flip-flop; reset forces flip-flop to 0
// - pwm pin always drives inverse of flip-flop level
// - duty written while running waits in shadow until next period irq
// - duty written while stopped becomes active compare immediately
// - duty read during pwm returns active stage, old value until period irq
// - stopping the timer holds the pwm pin at its level
// - run bit is control bit 3; clearing it stops the counter, except the lower control's run bit in 16-bit mode
// - initial-level bit is control bit 7; clearing it while stopped drives pin high
// - 16-bit mode cascades both counters, counting lower counter's source tick
// - 16-bit timer counts only after upper control run bit is set
// - 16-bit count match raises upper irq, clears counter, continues from zero
// - timer compare is unbuffered, takes effect at once; software avoids running change
package tcp_pkg;

  // ==========================================
  // register map
  localparam logic [3:0] ADDR_LOWER_CTRL = 4'h0;
  localparam logic [3:0] ADDR_UPPER_CTRL = 4'h1;
  localparam logic [3:0] ADDR_CMP_LOW = 4'h2;
  localparam logic [3:0] ADDR_CMP_HIGH = 4'h3;
  localparam logic [3:0] ADDR_DUTY_LOWER = 4'h4;
  localparam logic [3:0] ADDR_DUTY_UPPER = 4'h5;
  localparam logic [3:0] ADDR_COUNT_LOW = 4'h6;
  localparam logic [3:0] ADDR_COUNT_HIGH = 4'h7;
  localparam logic [3:0] ADDR_CONFIG = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'h9;

  // ==========================================
  // field positions and encodings
  localparam int CTRL_FFINIT_BIT = 7;
  localparam int CTRL_RUN_BIT = 3;
  localparam int CFG_DIVTAP_BIT = 0;
  localparam int CFG_SLOW_BIT = 1;
  localparam logic [2:0] MODE_PWM8 = 3'h3;
  localparam logic [2:0] MODE_TIMER16 = 3'h4;
  localparam logic [2:0] SEL_SLOWEST = 3'h0;
  localparam logic [2:0] SEL_HS_128 = 3'h1;
  localparam logic [2:0] SEL_HS_32 = 3'h2;
  localparam logic [2:0] SEL_HS_8 = 3'h3;
  localparam logic [2:0] SEL_LS = 3'h4;
  localparam logic [2:0] SEL_HS_2 = 3'h5;
  localparam logic [2:0] SEL_HS = 3'h6;

  // ==========================================
  // prescaler and widths
  localparam int DIV_W = 11;
  localparam logic [10:0] DIV_MASK_2048 = 11'h7FF;
  localparam logic [10:0] DIV_MASK_128 = 11'h07F;
  localparam logic [10:0] DIV_MASK_32 = 11'h01F;
  localparam logic [10:0] DIV_MASK_8 = 11'h007;
  localparam logic [10:0] DIV_MASK_2 = 11'h001;
  localparam logic [2:0] LS_DIV_LAST = 3'h7;
  localparam logic [7:0] COUNT_MAX = 8'hFF;

  // ==========================================
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CMP_RESET = 8'h00;
  localparam logic [7:0] DUTY_RESET = 8'h00;

  // ==========================================
  // carriers
  typedef struct packed {
    logic flipflop_initial_level;
    logic [2:0] clk_sel;
    logic run;
    logic [2:0] mode;
  } tcp_ctrl_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } tcp_bus_s;

  typedef struct packed {
    logic pwm_en;
    logic run;
    logic tick;
    logic casc_inc;
    logic casc_clr;
    logic duty_wr;
    logic ff_wr;
    logic ff_val;
    logic [7:0] wdata;
  } tcp_chan_cmd_s;

  typedef struct packed {
    logic [7:0] count;
    logic [7:0] duty;
    logic output_flipflop;
    logic pwm_out_pin;
    logic period;
  } tcp_chan_stat_s;

endpackage : tcp_pkg

// [hw/tcp_chan.sv]
module tcp_chan
  import tcp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // command from the pair
  input tcp_chan_cmd_s cmd_i,
  // state towards the pair
  output tcp_chan_stat_s stat_o
);

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] shadow;
    logic [7:0] active;
    logic ff;
    logic pin;
    logic period;
  } tcp_chan_state_s;

  localparam tcp_chan_state_s CHAN_RESET = '{
    cnt: 8'h00, shadow: DUTY_RESET, active: DUTY_RESET,
    ff: 1'b0, pin: 1'b1, period: 1'b0};

  tcp_chan_state_s state_reg;
  tcp_chan_state_s state_next;

  // ==========================================
  // next state
  always_comb begin
    state_next = state_reg;
    state_next.period = 1'b0;
    if (cmd_i.pwm_en && cmd_i.run && cmd_i.tick) begin
      if (state_reg.cnt == COUNT_MAX) begin
        state_next.cnt = 8'h00;
        state_next.ff = ~state_reg.ff;
        state_next.period = 1'b1;
        state_next.active = state_reg.shadow;
      end else begin
        state_next.cnt = state_reg.cnt + 8'h01;
        if (state_next.cnt == state_reg.active) begin
          state_next.ff = ~state_reg.ff;
        end
      end
    end else if (cmd_i.casc_clr) begin
      state_next.cnt = 8'h00;
    end else if (cmd_i.casc_inc) begin
      state_next.cnt = state_reg.cnt + 8'h01;
    end
    // preset only arrives while stopped, so the pin otherwise holds
    if (cmd_i.ff_wr) begin
      state_next.ff = cmd_i.ff_val;
    end
    if (cmd_i.duty_wr) begin
      state_next.shadow = cmd_i.wdata;
      if (!(cmd_i.pwm_en && cmd_i.run)) begin
        state_next.active = cmd_i.wdata;
      end
    end
    state_next.pin = ~state_next.ff;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= CHAN_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================
  // status
  always_comb begin
    stat_o.count = state_reg.cnt;
    stat_o.duty = state_reg.active;
    stat_o.output_flipflop = state_reg.ff;
    stat_o.pwm_out_pin = state_reg.pin;
    stat_o.period = state_reg.period;
  end

endmodule // tcp_chan

// [sim/tcp_pair_monitor.sv]
module tcp_pair_monitor
  import tcp_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // register port
  input tcp_bus_s bus_i,
  input wire logic [7:0] rdata_o,
  // pins and requests
  input wire logic low_speed_clock_i,
  input wire logic pwm_out_pin_lower_o,
  input wire logic pwm_out_pin_upper_o,
  input wire logic counter_period_irq_o,
  input wire logic upper_counter_irq_o
);
  // ==========
  // run bits shadowed from bus writes
  logic run_lo_reg;
  logic run_hi_reg;
  wire ctrl0_wr = bus_i.wr && (bus_i.addr == ADDR_LOWER_CTRL);
  wire ctrl1_wr = bus_i.wr && (bus_i.addr == ADDR_UPPER_CTRL);

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_lo_reg <= 1'b0;
      run_hi_reg <= 1'b0;
    end else begin
      if (ctrl0_wr) begin
        run_lo_reg <= bus_i.wdata[CTRL_RUN_BIT];
      end
      if (ctrl1_wr) begin
        run_hi_reg <= bus_i.wdata[CTRL_RUN_BIT];
      end
    end
  end

  // ==========
  // properties
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_lo_idle;
    !run_lo_reg && !run_hi_reg && !ctrl0_wr ##1 !run_lo_reg && !run_hi_reg;
  endsequence
  sequence s_lo_off;
    !run_lo_reg [*3];
  endsequence
  sequence s_hi_off;
    !run_hi_reg [*3];
  endsequence

  a_rdata_idle_zero: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
    else $error("read data outside read slot");
  a_unmapped_read_zero: assert property ($past(bus_i.rd) && $past(bus_i.addr) > ADDR_STATUS
    |-> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_status_pin_inverse: assert property (
    $past(bus_i.rd) && $past(bus_i.addr) == ADDR_STATUS |->
    rdata_o[1:0] == ~{$past(pwm_out_pin_upper_o), $past(pwm_out_pin_lower_o)})
    else $error("pin not inverse of flip-flop");
  a_period_irq_pulse: assert property (counter_period_irq_o |=> !counter_period_irq_o)
    else $error("period request longer than one cycle");
  a_period_pin_toggle: assert property (
    counter_period_irq_o |-> $past(pwm_out_pin_lower_o) != $past(pwm_out_pin_lower_o, 2))
    else $error("period request without overflow toggle");
  a_stop_holds_pin: assert property (s_lo_idle |-> $stable(pwm_out_pin_lower_o))
    else $error("stopped pin moved");
  a_preset_sets_pin: assert property (
    ctrl0_wr && !run_lo_reg |=> pwm_out_pin_lower_o == !$past(bus_i.wdata[CTRL_FFINIT_BIT]))
    else $error("preset did not reach pin");
  a_lower_quiet: assert property (s_lo_off |-> !counter_period_irq_o)
    else $error("stopped lower counter raised request");
  a_upper_quiet: assert property (s_hi_off |-> !upper_counter_irq_o)
    else $error("upper request without run bit");
endmodule // tcp_pair_monitor

bind tcp_pair tcp_pair_monitor u_mon (
  .sys_clk_i(sys_clk_i),
  .reset_n_i(reset_n_i),
  .bus_i(bus_i),
  .rdata_o(rdata_o),
  .low_speed_clock_i(low_speed_clock_i),
  .pwm_out_pin_lower_o(pwm_out_pin_lower_o),
  .pwm_out_pin_upper_o(pwm_out_pin_upper_o),
  .counter_period_irq_o(counter_period_irq_o),
  .upper_counter_irq_o(upper_counter_irq_o)
);

// [sim/tcp_pair_tb_top.sv]
module tcp_pair_tb_top import tcp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  tcp_bus_s bus = '0;
  logic ls_clk = 1'b0;
  logic [4:0] ls_div = 5'h00;
  logic [7:0] rdata, d, d2, got;
  logic pin_lo, pin_hi, irq_lo, irq_hi, p;
  logic ch = 1'b0;
  wire pin = ch ? pin_hi : pin_lo; // port latch taken as 1
  wire irq = ch ? irq_hi : irq_lo;
  logic [15:0] lo_cnt = '0, per_cnt = '0, irq_n = '0, lo_snap, per_snap, cmp, e, n;
  int err_count = 0;
  int tests_run = 0;
  int seed = 77;
  logic [1:0] cfgs [11] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h2};
  logic [2:0] sels [11] = '{SEL_HS, SEL_HS_2, SEL_HS_8, SEL_HS_32, SEL_HS_128, SEL_SLOWEST,
    SEL_LS, SEL_SLOWEST, SEL_SLOWEST, SEL_LS, SEL_HS};

  tcp_pair dut (
    .sys_clk_i(clk),
    .reset_n_i(rst_n),
    .bus_i(bus),
    .rdata_o(rdata),
    .low_speed_clock_i(ls_clk),
    .pwm_out_pin_lower_o(pin_lo),
    .pwm_out_pin_upper_o(pin_hi),
    .counter_period_irq_o(irq_lo),
    .upper_counter_irq_o(irq_hi)
  );

  initial begin
    forever #10 clk = ~clk;
  end

  // ==========
  // low-speed clock, 40 system cycles a period
  always @(posedge clk) begin
    ls_div <= (ls_div == 5'h13) ? 5'h00 : ls_div + 5'h01;
    if (ls_div == 5'h13) ls_clk <= ~ls_clk;
  end

  // ==========
  // low time and period between requests
  always @(posedge clk) begin
    if (irq === 1'b1) begin
      lo_snap <= lo_cnt + 16'(pin === 1'b0);
      per_snap <= per_cnt + 16'h0001;
      lo_cnt <= '0;
      per_cnt <= '0;
      irq_n <= irq_n + 16'h0001;
    end else begin
      lo_cnt <= lo_cnt + 16'(pin === 1'b0);
      per_cnt <= per_cnt + 16'h0001;
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] x, input string m);
    tests_run++;
    if (g !== x) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, x);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus <= '0;
    #1 v = rdata;
  endtask

  task automatic wait_irq;
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (irq !== 1'b1 && k < 20000);
    if (k >= 20000) chk(16'h0000, 16'h0001, "no request");
    #1;
  endtask

  function automatic logic [15:0] exp_low(input logic pol, input logic [7:0] v);
    return pol ? 16'(v) : 16'h0100 - 16'(v);
  endfunction

  function automatic logic [15:0] exp_per(input logic [1:0] cfg, input logic [2:0] sel);
    logic [15:0] div;
    case (sel)
      SEL_HS: div = 16'h0001;
      SEL_HS_2: div = 16'h0002;
      SEL_HS_8: div = 16'h0008;
      SEL_HS_32: div = 16'h0020;
      SEL_HS_128: div = 16'h0080;
      SEL_LS: div = 16'h0028;
      default: div = (cfg != 2'h0) ? 16'h0140 : 16'h0800;
    endcase
    if (cfg[1] && sel != SEL_LS && sel != SEL_SLOWEST) div = 16'h0000;
    return div * 16'h0004;
  endfunction

  function automatic logic [7:0] rnd_duty();
    return 8'h02 + 8'({$random(seed)} % 253);
  endfunction

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    end_of_test;
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk(16'({pin_hi, pin_lo}), 16'h0003, "pins after reset");
    rd(ADDR_DUTY_LOWER, got);
    chk(16'(got), 16'h0000, "duty reset");
    for (int a = 10; a < 16; a++) begin
      rd(4'(a), got);
      chk(16'(got), 16'h0000, "unmapped read");
    end
    for (int c = 0; c < 2; c++) begin
      for (int pol = 0; pol < 2; pol++) begin
        ch = c[0];
        d = (pol == 0) ? 8'h02 : rnd_duty();
        d2 = (pol == 0) ? 8'hFE : rnd_duty();
        wr(4'(c), {pol[0], SEL_HS, 1'b0, MODE_PWM8});
        #1 chk(16'(pin), 16'(!pol[0]), "preset");
        wr(4'(4 + c), d);
        rd(4'(4 + c), got);
        chk(16'(got), 16'(d), "stopped duty");
        wr(4'(c), {pol[0], SEL_HS, 1'b1, MODE_PWM8});
        wait_irq;
        wr(4'(4 + c), d2);
        rd(4'(4 + c), got);
        chk(16'(got), 16'(d), "duty read while running");
        wait_irq;
        chk(lo_snap, exp_low(pol[0], d), "low time");
        chk(per_snap, 16'h0100, "pwm period");
        rd(4'(4 + c), got);
        chk(16'(got), 16'(d2), "duty after request");
        wait_irq;
        chk(lo_snap, exp_low(pol[0], d2), "new low time");
        wr(4'(c), {pol[0], SEL_HS, 1'b0, MODE_PWM8});
        #1 p = pin;
        repeat (40) @(posedge clk);
        chk(16'(pin), 16'(p), "stopped pin");
        wr(4'(c), {1'b0, SEL_HS, 1'b0, MODE_PWM8});
        #1 chk(16'(pin), 16'h0001, "pin high");
        rd(ADDR_STATUS, got);
        chk(16'(got[c]), 16'h0000, "status flip-flop");
      end
    end
    cmp = {8'h01, 8'($random(seed))};
    wr(ADDR_UPPER_CTRL, 8'h00);
    wr(ADDR_CMP_HIGH, cmp[15:8]);
    wr(ADDR_CMP_LOW, cmp[7:0]);
    wr(ADDR_LOWER_CTRL, {1'b0, SEL_HS, 1'b0, MODE_TIMER16});
    n = irq_n;
    repeat (100) @(posedge clk);
    chk(irq_n, n, "held before start");
    rd(ADDR_COUNT_LOW, got);
    chk(16'(got), 16'h0000, "lower count held before start");
    rd(ADDR_COUNT_HIGH, got);
    chk(16'(got), 16'h0000, "upper count held before start");
    wr(ADDR_UPPER_CTRL, 8'h08);
    wait_irq;
    wait_irq;
    chk(per_snap, cmp, "cascade period");
    for (int i = 0; i < 11; i++) begin
      wr(ADDR_UPPER_CTRL, 8'h00);
      wr(ADDR_CONFIG, {6'h00, cfgs[i]});
      rd(ADDR_CONFIG, got);
      chk(16'(got), 16'(cfgs[i]), "config readback");
      wr(ADDR_CMP_HIGH, 8'h00);
      wr(ADDR_CMP_LOW, 8'h04);
      wr(ADDR_LOWER_CTRL, {1'b0, sels[i], 1'b0, MODE_TIMER16});
      wr(ADDR_UPPER_CTRL, 8'h08);
      e = exp_per(cfgs[i], sels[i]);
      if (e == 16'h0000) begin
        n = irq_n;
        repeat (400) @(posedge clk);
        chk(irq_n, n, "fast tap in slow mode");
      end else begin
        wait_irq;
        wait_irq;
        chk(per_snap, e, "tap period");
      end
    end
    end_of_test;
  end
endmodule // tcp_pair_tb_top
